// >>> rtl/watchdog_pkg.sv
// Constants, carrier structs and state layout of the countdown watchdog.
// Assumes a single 200 MHz system clock and an APB master with 32-bit data.
package watchdog_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 200;
  localparam int DECREMENT_CYCLES = 3072;
  localparam int RST_PULSE_NS     = 500;
  localparam int RST_PULSE_CYCLES = (RST_PULSE_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // Widths, map and field positions
  // ----------------------------------------------------------------
  localparam int CNT_W   = 7;
  localparam int PRESC_W = 12;
  localparam int PULSE_W = 8;
  localparam int ADDR_W  = 8;

  localparam logic [ADDR_W-1:0] WDG_CTRL_ADDR   = 8'hD8;
  localparam logic [ADDR_W-1:0] WDG_STATUS_ADDR = 8'hDC;
  localparam logic [7:0]        WDG_CTRL_RESET  = 8'hFE;
  localparam logic [CNT_W-1:0]  CNT_EXPIRE_FROM = 7'h40;

  localparam int ARM_BIT     = 0;
  localparam int RESTART_BIT = 1;
  localparam int ST_ARMED    = 0;
  localparam int ST_WAIT     = 1;
  localparam int ST_STOP     = 2;
  localparam int ST_HW_OPT   = 3;
  localparam int ST_EXT_OPT  = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP} power_mode_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    apb_rsp_t           rsp;
    logic               strap_done;
    logic               hw_opt;
    logic               ext_opt;
    logic               armed;
    logic [CNT_W-1:0]   cnt;
    logic [PRESC_W-1:0] presc;
    logic [PULSE_W-1:0] pulse;
    logic               rst_n;
    power_mode_t        mode;
    logic               wait_o;
    logic               stop_o;
  } wdg_state_t;

  // Counter bits sit reversed in bits 7:2, restart flag in bit 1
  function automatic logic [7:0] ctrl_image(input logic [CNT_W-1:0] cnt,
                                            input logic armed);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < CNT_W - 1; i++) begin
      v[7-i] = cnt[i];
    end
    v[RESTART_BIT] = cnt[CNT_W-1];
    v[ARM_BIT]     = armed;
    return v;
  endfunction : ctrl_image

  function automatic logic [CNT_W-1:0] ctrl_count(input logic [7:0] v);
    logic [CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < CNT_W - 1; i++) begin
      c[i] = v[7-i];
    end
    c[CNT_W-1] = v[RESTART_BIT];
    return c;
  endfunction : ctrl_count

endpackage : watchdog_pkg

// >>> rtl/watchdog_countdown_reset.sv
// Countdown watchdog with software restart, APB register access and STOP gating.
// Assumes option straps stable around reset and all inputs synchronous to clk_sys_in.
`timescale 1ns/1ps

module watchdog_countdown_reset
  import watchdog_pkg::*;
#(
  parameter int DEC_CYCLES   = watchdog_pkg::DECREMENT_CYCLES,
  parameter int PULSE_CYCLES = watchdog_pkg::RST_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  nrst_in,
  // Register bus
  input  wire watchdog_pkg::apb_req_t apb_in,
  output watchdog_pkg::apb_rsp_t      apb_out,
  // Option straps
  input  wire logic                  hardware_arming_option_in,
  input  wire logic                  external_stop_gating_option_in,
  // Core power control
  input  wire logic                  stop_instr_in,
  input  wire logic                  wake_in,
  input  wire logic                  nmi_in,
  output logic                       wait_mode_out,
  output logic                       stop_mode_out,
  // Reset pin drive
  output logic                       reset_pin_n_out
);
  import watchdog_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdg_state_t s_q;
  wdg_state_t s_d;
  logic       access;
  logic       taken;
  logic       wr_ctrl;
  logic       tick;
  logic       fire;
  logic [7:0] wbyte;

  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(DEC_CYCLES - 1);
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES);

  always_comb begin
    s_d     = s_q;
    fire    = 1'b0;
    wbyte   = apb_in.pwdata[7:0];
    access  = apb_in.psel & apb_in.penable;
    taken   = access & s_q.rsp.pready;
    wr_ctrl = taken & apb_in.pwrite & (apb_in.paddr == WDG_CTRL_ADDR);
    tick    = (s_q.presc == PRESC_LAST) & (s_q.mode != MODE_STOP);

    // ----------------------------------------------------------------
    // APB slave: one wait state, answer on second access cycle
    // ----------------------------------------------------------------
    s_d.rsp.pready = access & ~s_q.rsp.pready;
    if (access & ~s_q.rsp.pready) begin
      s_d.rsp.pslverr = 1'b0;
      s_d.rsp.prdata  = '0;
      case (apb_in.paddr)
        WDG_CTRL_ADDR: begin
          // Arming bit reads back the armed state
          s_d.rsp.prdata[7:0] = ctrl_image(s_q.cnt, s_q.armed);
        end
        WDG_STATUS_ADDR: begin
          s_d.rsp.prdata[ST_ARMED]   = s_q.armed;
          s_d.rsp.prdata[ST_WAIT]    = s_q.mode == MODE_WAIT;
          s_d.rsp.prdata[ST_STOP]    = s_q.mode == MODE_STOP;
          s_d.rsp.prdata[ST_HW_OPT]  = s_q.hw_opt;
          s_d.rsp.prdata[ST_EXT_OPT] = s_q.ext_opt;
        end
        default: begin
          s_d.rsp.pslverr = 1'b1;
        end
      endcase
    end else if (taken) begin
      s_d.rsp.pslverr = 1'b0;
      s_d.rsp.prdata  = '0;
    end

    // ----------------------------------------------------------------
    // Option straps, caught on the first edge after reset release
    // ----------------------------------------------------------------
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.hw_opt     = hardware_arming_option_in;
      s_d.ext_opt    = external_stop_gating_option_in;
      s_d.armed      = hardware_arming_option_in;
    end

    // ----------------------------------------------------------------
    // Prescaler and countdown
    // ----------------------------------------------------------------
    // WAIT keeps counting; STOP only freezes
    if (s_q.mode != MODE_STOP) begin
      s_d.presc = tick ? '0 : s_q.presc + 1'b1;
    end
    if (tick) begin
      s_d.cnt = s_q.cnt - 1'b1;
      if (s_q.armed && s_q.cnt == CNT_EXPIRE_FROM) begin
        fire = 1'b1;
      end
    end

    // Write beats a coincident decrement
    if (wr_ctrl) begin
      s_d.cnt   = ctrl_count(wbyte);
      s_d.presc = '0;
      fire      = 1'b0;
      s_d.armed = s_q.armed | s_q.hw_opt | wbyte[ARM_BIT];
      if (s_d.armed && !wbyte[RESTART_BIT]) begin
        fire = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Reset pulse, independent of later counter activity
    // ----------------------------------------------------------------
    // Cycle-counted pulse
    if (s_q.pulse != '0) begin
      s_d.pulse = s_q.pulse - 1'b1;
    end else if (fire) begin
      s_d.pulse = PULSE_LOAD;
    end
    s_d.rst_n = s_d.pulse == '0;

    // ----------------------------------------------------------------
    // STOP / WAIT handling
    // ----------------------------------------------------------------
    case (s_q.mode)
      MODE_RUN: begin
        if (stop_instr_in) begin
          if (!s_q.armed) begin
            s_d.mode = MODE_STOP;
          end else if (s_q.ext_opt && nmi_in) begin
            s_d.mode = MODE_STOP;
          end else begin
            s_d.mode = MODE_WAIT;
          end
        end
      end
      MODE_WAIT, MODE_STOP: begin
        if (wake_in) begin
          s_d.mode = MODE_RUN;
        end
      end
      default: begin
        s_d.mode = MODE_RUN;
      end
    endcase
    s_d.wait_o = s_d.mode == MODE_WAIT;
    s_d.stop_o = s_d.mode == MODE_STOP;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q            <= '0;
      // Count and restart flag all ones, disarmed
      s_q.cnt        <= ctrl_count(WDG_CTRL_RESET);
      s_q.armed      <= WDG_CTRL_RESET[ARM_BIT];
      s_q.rst_n      <= 1'b1;
      s_q.mode       <= MODE_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_out         = s_q.rsp;
  assign wait_mode_out   = s_q.wait_o;
  assign stop_mode_out   = s_q.stop_o;
  assign reset_pin_n_out = s_q.rst_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int PULSE_HOLD = PULSE_CYCLES - 1;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  property p_hw_armed;
    s_q.strap_done && s_q.hw_opt |-> s_q.armed;
  endproperty
  a_hw_armed: assert property (p_hw_armed)
    else $error("hardware option but watchdog not armed");

  property p_arm_sticky;
    s_q.armed |=> s_q.armed;
  endproperty
  a_arm_sticky: assert property (p_arm_sticky)
    else $error("armed watchdog became disarmed");

  property p_sw_start_disarmed;
    s_q.strap_done && !$past(s_q.strap_done) && !s_q.hw_opt |-> !s_q.armed;
  endproperty
  a_sw_start_disarmed: assert property (p_sw_start_disarmed)
    else $error("software option armed after reset");

  property p_decrement;
    tick && !wr_ctrl |=> s_q.cnt == $past(s_q.cnt) - 1'b1;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("count did not decrement at interval end");

  property p_expire;
    tick && !wr_ctrl && s_q.armed && s_q.cnt == CNT_EXPIRE_FROM && s_q.pulse == '0
      |=> !reset_pin_n_out;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry did not drive reset");

  property p_soft_reset;
    wr_ctrl && (s_q.armed || s_q.hw_opt || wbyte[ARM_BIT]) && !wbyte[RESTART_BIT]
      && s_q.pulse == '0 |=> !reset_pin_n_out;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("software reset write not honoured");

  property p_no_reset_disarmed;
    $fell(reset_pin_n_out) |-> s_q.armed;
  endproperty
  a_no_reset_disarmed: assert property (p_no_reset_disarmed)
    else $error("reset while disarmed");

  property p_pulse_len;
    $fell(reset_pin_n_out) |-> ##PULSE_HOLD !reset_pin_n_out ##1 reset_pin_n_out;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse length wrong");

  property p_stop_disarmed;
    s_q.mode == MODE_RUN && stop_instr_in && !s_q.armed |=> s_q.mode == MODE_STOP;
  endproperty
  a_stop_disarmed: assert property (p_stop_disarmed)
    else $error("disarmed stop did not enter STOP");

  property p_stop_as_wait;
    s_q.mode == MODE_RUN && stop_instr_in && s_q.armed && !s_q.ext_opt
      |=> s_q.mode == MODE_WAIT && wait_mode_out;
  endproperty
  a_stop_as_wait: assert property (p_stop_as_wait)
    else $error("armed stop not treated as wait");

  property p_stop_gated;
    s_q.mode == MODE_RUN && stop_instr_in && s_q.armed && s_q.ext_opt
      |=> s_q.mode == (nmi_in ? MODE_STOP : MODE_WAIT);
  endproperty
  a_stop_gated: assert property (p_stop_gated)
    else $error("NMI gating of stop wrong");

  property p_frozen;
    s_q.mode == MODE_STOP && !wr_ctrl |=> $stable(s_q.cnt) && $stable(s_q.presc);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("counter moved during STOP");

  property p_wake;
    s_q.mode == MODE_STOP && wake_in |=> s_q.mode == MODE_RUN && !stop_mode_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not leave STOP");

  property p_read_layout;
    s_q.rsp.pready && !s_q.rsp.pslverr && !apb_in.pwrite && apb_in.paddr == WDG_CTRL_ADDR
      |-> s_q.rsp.prdata[7] == $past(s_q.cnt[0]) && s_q.rsp.prdata[2] == $past(s_q.cnt[5])
          && s_q.rsp.prdata[1] == $past(s_q.cnt[6]);
  endproperty
  a_read_layout: assert property (p_read_layout)
    else $error("register read layout wrong");

  property p_reset_value;
    !s_q.strap_done |-> s_q.cnt == ctrl_count(WDG_CTRL_RESET) && !s_q.armed;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("register reset value wrong");

  property p_reload;
    wr_ctrl |=> s_q.presc == '0 && s_q.cnt == ctrl_count($past(wbyte));
  endproperty
  a_reload: assert property (p_reload)
    else $error("write did not reload count and interval");

  property p_hw_arm_reads;
    s_q.rsp.pready && !apb_in.pwrite && apb_in.paddr == WDG_CTRL_ADDR && s_q.hw_opt
      |-> s_q.rsp.prdata[ARM_BIT];
  endproperty
  a_hw_arm_reads: assert property (p_hw_arm_reads)
    else $error("hardware option arming bit read wrong");

  property p_wait_counts;
    s_q.mode == MODE_WAIT && !tick && !wr_ctrl |=> s_q.presc == $past(s_q.presc) + 1'b1;
  endproperty
  a_wait_counts: assert property (p_wait_counts)
    else $error("prescaler stalled during WAIT");

  property p_pulse_count;
    s_q.pulse != '0 |=> s_q.pulse == $past(s_q.pulse) - 1'b1;
  endproperty
  a_pulse_count: assert property (p_pulse_count)
    else $error("reset pulse counter disturbed");

  c_expire:   cover property (tick && s_q.armed && s_q.cnt == CNT_EXPIRE_FROM);
  c_soft_rst: cover property (wr_ctrl && s_q.armed && !wbyte[RESTART_BIT]);
  c_stop:     cover property (s_q.mode == MODE_STOP ##1 wake_in);
  c_wait:     cover property (s_q.armed && stop_instr_in ##1 s_q.mode == MODE_WAIT);

endmodule : watchdog_countdown_reset

// >>> tb/core_model.sv
// Stand-in for the core and the reset circuit beside the watchdog.
// Assumes the watchdog clock; pulses change just after a rising edge.
`timescale 1ns/1ps
module core_model (
  // Clock
  input  wire logic clk_in,
  // Watchdog side
  input  wire logic reset_pin_n_in,
  output logic      stop_instr_out,
  output logic      wake_out,
  // Reset pulse log
  output int        pulses_out,
  output int        last_len_out
);
  int run = 0;
  initial begin
    stop_instr_out = 1'b0;
    wake_out       = 1'b0;
    pulses_out     = 0;
    last_len_out   = 0;
  end
  // One-cycle STOP (0) or wake (1) pulse
  task automatic pulse(input logic which);
    @(posedge clk_in);
    if (which) wake_out <= 1'b1;
    else stop_instr_out <= 1'b1;
    @(posedge clk_in);
    wake_out       <= 1'b0;
    stop_instr_out <= 1'b0;
  endtask : pulse
  // Low cycles counted per pulse; pin not fed back so state survives
  always @(posedge clk_in) begin
    if (!reset_pin_n_in) run <= run + 1;
    else if (run != 0) begin
      pulses_out   <= pulses_out + 1;
      last_len_out <= run;
      run          <= 0;
    end
  end
endmodule : core_model

// >>> tb/tb_top.sv
// Self-checking bench for the countdown watchdog over APB.
// Assumes the core model above; shortened decrement interval.
`timescale 1ns/1ps
module tb_top;
  import watchdog_pkg::*;
  localparam int DEC = 64;
  localparam int PUL = 100;
  logic       clk_sys_in, nrst_in, hw_opt, ext_opt, nmi, stop_p, wake_p, wait_m, stop_m, pin_n;
  apb_req_t   req;
  apb_rsp_t   rsp;
  int         pulses, last_len, err_count, comparisons, p0;
  int         cyc = 0;
  logic [31:0] rd;
  logic       err;
  logic [6:0] c;
  watchdog_countdown_reset #(.DEC_CYCLES(DEC), .PULSE_CYCLES(PUL)) u_watchdog_countdown_reset (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .apb_in(req), .apb_out(rsp),
    .hardware_arming_option_in(hw_opt), .external_stop_gating_option_in(ext_opt),
    .stop_instr_in(stop_p), .wake_in(wake_p), .nmi_in(nmi), .wait_mode_out(wait_m),
    .stop_mode_out(stop_m), .reset_pin_n_out(pin_n));
  core_model u_core_model (.clk_in(clk_sys_in), .reset_pin_n_in(pin_n),
    .stop_instr_out(stop_p), .wake_out(wake_p), .pulses_out(pulses), .last_len_out(last_len));
  // ----------------------------------------------------------------
  // Clock, timeout, helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] img(input logic [6:0] n, input logic a);
    for (int i = 0; i < 6; i++) img[7-i] = n[i];
    img[1] = n[6];
    img[0] = a;
  endfunction : img
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys_in);
    req.penable <= 1'b1;
    // Only the bench timeout ends a missing answer
    @(posedge clk_sys_in);
    while (rsp.pready !== 1'b1) @(posedge clk_sys_in);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rd_cnt(output logic [6:0] n);
    logic [7:0] v;
    v = 8'h00;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, WDG_CTRL_ADDR, 32'h0);
      chk("ctrl read error", 0, err);
      if (k > 0 && rd[7:0] === v) break;
      v = rd[7:0];
    end
    for (int i = 0; i < 6; i++) n[i] = v[7-i];
    n[6] = v[1];
  endtask : rd_cnt
  task automatic wr(input logic [7:0] v);
    apb(1'b1, WDG_CTRL_ADDR, {24'h0, v});
  endtask : wr
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : settle
  task automatic do_reset(input logic hw, input logic ext);
    @(posedge clk_sys_in);
    nrst_in <= 1'b0;
    hw_opt  <= hw;
    ext_opt <= ext;
    settle(2);
    nrst_in <= 1'b1;
  endtask : do_reset
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_refuse();
    apb(1'b0, WDG_CTRL_ADDR, 32'h0);
    chk("reset value", 32'hFE, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 1, err);
  endtask : t_reset_and_refuse
  task automatic t_free_timer();
    wr(img(7'h50, 1'b0));
    settle(DEC * 3 + 32);
    rd_cnt(c);
    chk("timer count", 7'h4D, c);
  endtask : t_free_timer
  task automatic t_disarmed_wrap();
    p0 = pulses;
    // Upper data bits must be ignored
    apb(1'b1, WDG_CTRL_ADDR, 32'hA5A5A502);
    settle(DEC + 20);
    rd_cnt(c);
    chk("wrap count", 7'h3F, c);
    chk("no pulse", p0, pulses);
  endtask : t_disarmed_wrap
  task automatic t_stop_disarmed();
    u_core_model.pulse(1'b0);
    @(negedge clk_sys_in);
    chk("stop disarmed", 1, stop_m);
    u_core_model.pulse(1'b1);
    @(negedge clk_sys_in);
    chk("woken", 0, stop_m);
  endtask : t_stop_disarmed
  task automatic t_expiry();
    p0 = pulses;
    wr(img(7'h41, 1'b1));
    settle(DEC * 2 + PUL + 40);
    chk("expiry pulse", p0 + 1, pulses);
    chk("pulse length", PUL, last_len);
    wr(8'hFE);
    apb(1'b0, WDG_CTRL_ADDR, 32'h0);
    chk("arm sticky", 1, rd[0]);
  endtask : t_expiry
  task automatic t_wait_counts();
    wr(img(7'h60, 1'b1));
    // NMI level must not matter without gating
    nmi <= 1'b1;
    u_core_model.pulse(1'b0);
    @(negedge clk_sys_in);
    chk("stop as wait", 2'b10, {wait_m, stop_m});
    settle(DEC * 2 + 20);
    rd_cnt(c);
    chk("wait count", 7'h5E, c);
    u_core_model.pulse(1'b1);
  endtask : t_wait_counts
  task automatic t_soft_reset();
    p0 = pulses;
    wr(8'hFD);
    settle(PUL + 10);
    chk("soft reset", p0 + 1, pulses);
  endtask : t_soft_reset
  task automatic t_gated_stop();
    wr(img(7'h60, 1'b1));
    nmi <= 1'b0;
    u_core_model.pulse(1'b0);
    @(negedge clk_sys_in);
    chk("nmi low wait", 2'b10, {wait_m, stop_m});
    u_core_model.pulse(1'b1);
    nmi <= 1'b1;
    u_core_model.pulse(1'b0);
    @(negedge clk_sys_in);
    chk("nmi high stop", 2'b01, {wait_m, stop_m});
    settle(DEC * 3);
    apb(1'b0, WDG_STATUS_ADDR, 32'h0);
    chk("status in stop", 32'h15, rd);
    u_core_model.pulse(1'b1);
    rd_cnt(c);
    chk("frozen count", 7'h60, c);
    settle(DEC * 2 + 10);
    rd_cnt(c);
    chk("resumed count", 7'h5E, c);
  endtask : t_gated_stop
  task automatic t_hw_option();
    apb(1'b0, WDG_CTRL_ADDR, 32'h0);
    chk("hw reset value", 32'hFF, rd);
    apb(1'b0, WDG_STATUS_ADDR, 32'h0);
    chk("hw status", 32'h09, rd);
    p0 = pulses;
    wr(8'h02);
    settle(DEC + PUL + 20);
    chk("hw armed", p0 + 1, pulses);
  endtask : t_hw_option
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst_in, hw_opt, ext_opt, nmi} = 4'b0000;
    req         = '0;
    err_count   = 0;
    comparisons = 0;
    do_reset(1'b0, 1'b0);
    t_reset_and_refuse();
    t_free_timer();
    t_disarmed_wrap();
    t_stop_disarmed();
    t_expiry();
    t_wait_counts();
    t_soft_reset();
    do_reset(1'b0, 1'b1);
    t_gated_stop();
    do_reset(1'b1, 1'b0);
    t_hw_option();
    close_out();
  end
endmodule : tb_top
